// >>> atmcr_host.sv
// atmcr_host: host model issuing byte register accesses and pressure samples
// assumes the bench calls its tasks; all signals move on the falling edge
`timescale 1ns/10ps
`default_nettype none
module atmcr_host (
   input  wire logic        i_clk,
   output logic             o_wr_en,
   output logic             o_rd_en,
   output logic [7:0]       o_addr,
   output logic [7:0]       o_wdata,
   output logic             o_p_sample_valid,
   output logic [19:0]      o_p_sample
);
   // ****************************************************************
   // bus driving
   // ****************************************************************
   initial begin
      o_wr_en          = 1'b0;
      o_rd_en          = 1'b0;
      o_addr           = 8'h00;
      o_wdata          = 8'h00;
      o_p_sample_valid = 1'b0;
      o_p_sample       = 20'h00000;
   end

   // one access per call; released address and data lines show the inverse, not stale values; enables drop to 0
   task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_wr_en <= w;
      o_rd_en <= r;
      o_addr  <= a;
      o_wdata <= d;
      @(negedge i_clk);
      o_wr_en <= 1'b0;
      o_rd_en <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~d;
   endtask : acc

   task automatic smp(input logic [19:0] s);
      @(negedge i_clk);
      o_p_sample_valid <= 1'b1;
      o_p_sample       <= s;
      @(negedge i_clk);
      o_p_sample_valid <= 1'b0;
      o_p_sample       <= ~s;
   endtask : smp

   task automatic clr();
      acc(1'b1, 1'b0, 8'h1c, 8'h00);
      acc(1'b1, 1'b0, 8'h1d, 8'h00);
      acc(1'b1, 1'b0, 8'h1e, 8'h00);
   endtask : clr
endmodule : atmcr_host
`default_nettype wire

// >>> atmcr_min_cmp.sv
// atmcr_min_cmp: decides whether a new pressure sample replaces the captured minimum
// assumes sample and stored value share the main clock; purely combinational
`timescale 1ns/10ps
`default_nettype none
module atmcr_min_cmp (
   input  wire logic [atmcr_pkg::PRES_W-1:0] i_cur,
   input  wire logic                         i_valid,
   input  wire logic [atmcr_pkg::PRES_W-1:0] i_sample,
   output logic                              o_take,
   output logic      [atmcr_pkg::PRES_W-1:0] o_next
);
   import atmcr_pkg::*;

   // ****************************************************************
   // compare
   // ****************************************************************
   always_comb begin
      o_take = i_valid && ((i_cur == RST_PRES) || (i_sample < i_cur));
      o_next = o_take ? i_sample : i_cur;
   end

endmodule : atmcr_min_cmp
`default_nettype wire

// >>> atmcr_pkg.sv
// atmcr_pkg: constants and state type for the alarm threshold and minimum capture bank
// assumes an upstream serial port decoder hands over byte-wide register accesses
package atmcr_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 8;
   localparam int PRES_W    = 20;
   localparam int HALF_W    = 16;

   // ****************************************************************
   // byte addresses
   // ****************************************************************
   localparam logic [7:0] ADDR_PRESSURE_TARGET_HIGH = 8'h16;
   localparam logic [7:0] ADDR_PRESSURE_TARGET_LOW  = 8'h17;
   localparam logic [7:0] ADDR_TEMPERATURE_TARGET   = 8'h18;
   localparam logic [7:0] ADDR_PRESSURE_WINDOW_HIGH = 8'h19;
   localparam logic [7:0] ADDR_PRESSURE_WINDOW_LOW  = 8'h1a;
   localparam logic [7:0] ADDR_TEMPERATURE_WINDOW   = 8'h1b;
   localparam logic [7:0] ADDR_MIN_PRESSURE_HIGH    = 8'h1c;
   localparam logic [7:0] ADDR_MIN_PRESSURE_MID     = 8'h1d;
   localparam logic [7:0] ADDR_MIN_PRESSURE_LOW     = 8'h1e;

   // ****************************************************************
   // field positions of the captured minimum
   // ****************************************************************
   localparam int MIN_HIGH_LSB = 12;
   localparam int MIN_MID_LSB  = 4;
   localparam int MIN_LOW_TOP  = 3;
   localparam int LOW_FLD_LSB  = 4;
   localparam logic [3:0] LOW_RSVD_VAL = 4'h0;

   // ****************************************************************
   // reset values and the unmapped read value
   // ****************************************************************
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_HALF  = 16'h0000;
   localparam logic [19:0] RST_PRES  = 20'h00000;
   localparam logic [7:0]  RDATA_UNMAPPED = 8'h00;

   typedef struct packed {
      logic [15:0] pressure_target_value;
      logic [7:0]  temperature_target;
      logic [15:0] pressure_window_reg;
      logic [7:0]  t_wnd;
      logic [19:0] p_min;
      logic [7:0]  rdata;
   } atmcr_state_t;

endpackage : atmcr_pkg

// >>> atmcr_regs.sv
// atmcr_regs: alarm targets, alarm windows and captured minimum pressure bank
// assumes a byte register port from the serial decoder and samples on the same clock
`timescale 1ns/10ps
`default_nettype none

module atmcr_regs (
   input  wire logic                           i_clk,
   input  wire logic                           i_nrst,
   input  wire logic                           i_wr_en,
   input  wire logic                           i_rd_en,
   input  wire logic [atmcr_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [atmcr_pkg::DATA_W-1:0]   i_wdata,
   output logic      [atmcr_pkg::DATA_W-1:0]   o_rdata,
   input  wire logic                           i_p_sample_valid,
   input  wire logic [atmcr_pkg::PRES_W-1:0]   i_p_sample,
   output logic      [atmcr_pkg::HALF_W-1:0]   o_pressure_target_value,
   output logic      [atmcr_pkg::DATA_W-1:0]   o_temperature_target_value,
   output logic      [atmcr_pkg::HALF_W-1:0]   o_pressure_window_reg,
   output logic      [atmcr_pkg::DATA_W-1:0]   o_temperature_window_value,
   output logic      [atmcr_pkg::PRES_W-1:0]   o_min_pressure
);
   import atmcr_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   atmcr_state_t state_q;
   atmcr_state_t state_d;
   logic [PRES_W-1:0] min_after_wr;
   logic [PRES_W-1:0] min_next;
   logic              min_take;
   logic [7:0]        rd_byte;

   // ****************************************************************
   // capture unit
   // ****************************************************************
   // host write is applied first so a sample in the same cycle is never lost
   atmcr_min_cmp u_min_cmp (
      .i_cur    (min_after_wr),
      .i_valid  (i_p_sample_valid),
      .i_sample (i_p_sample),
      .o_take   (min_take),
      .o_next   (min_next)
   );

   // ****************************************************************
   // read mux
   // ****************************************************************
   always_comb begin
      case (i_addr)
         ADDR_PRESSURE_TARGET_HIGH: rd_byte = state_q.pressure_target_value[15:8];
         ADDR_PRESSURE_TARGET_LOW:  rd_byte = state_q.pressure_target_value[7:0];
         ADDR_TEMPERATURE_TARGET:   rd_byte = state_q.temperature_target;
         ADDR_PRESSURE_WINDOW_HIGH: rd_byte = state_q.pressure_window_reg[15:8];
         ADDR_PRESSURE_WINDOW_LOW:  rd_byte = state_q.pressure_window_reg[7:0];
         ADDR_TEMPERATURE_WINDOW:   rd_byte = state_q.t_wnd;
         ADDR_MIN_PRESSURE_HIGH:    rd_byte = state_q.p_min[PRES_W-1:MIN_HIGH_LSB];
         ADDR_MIN_PRESSURE_MID:     rd_byte = state_q.p_min[MIN_HIGH_LSB-1:MIN_MID_LSB];
         ADDR_MIN_PRESSURE_LOW:     rd_byte = {state_q.p_min[MIN_LOW_TOP:0], LOW_RSVD_VAL};
         default:                   rd_byte = RDATA_UNMAPPED;
      endcase
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      state_d      = state_q;
      min_after_wr = state_q.p_min;
      if (i_wr_en) begin
         case (i_addr)
            ADDR_PRESSURE_TARGET_HIGH: state_d.pressure_target_value[15:8] = i_wdata;
            ADDR_PRESSURE_TARGET_LOW:  state_d.pressure_target_value[7:0]  = i_wdata;
            ADDR_TEMPERATURE_TARGET:   state_d.temperature_target = i_wdata;
            ADDR_PRESSURE_WINDOW_HIGH: state_d.pressure_window_reg[15:8] = i_wdata;
            ADDR_PRESSURE_WINDOW_LOW:  state_d.pressure_window_reg[7:0]  = i_wdata;
            ADDR_TEMPERATURE_WINDOW:   state_d.t_wnd = i_wdata;
            ADDR_MIN_PRESSURE_HIGH: begin
               min_after_wr[PRES_W-1:MIN_HIGH_LSB] = i_wdata;
            end
            ADDR_MIN_PRESSURE_MID: begin
               min_after_wr[MIN_HIGH_LSB-1:MIN_MID_LSB] = i_wdata;
            end
            ADDR_MIN_PRESSURE_LOW: begin
               min_after_wr[MIN_LOW_TOP:0] = i_wdata[7:LOW_FLD_LSB];
            end
            default: begin
               min_after_wr = state_q.p_min;
            end
         endcase
      end
      state_d.p_min = min_next;
      state_d.rdata = i_rd_en ? rd_byte : state_q.rdata;
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q.pressure_target_value <= RST_HALF;
         state_q.temperature_target <= RST_BYTE;
         state_q.pressure_window_reg <= RST_HALF;
         state_q.t_wnd <= RST_BYTE;
         state_q.p_min <= RST_PRES;
         state_q.rdata <= RST_BYTE;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_rdata                    = state_q.rdata;
   assign o_pressure_target_value    = state_q.pressure_target_value;
   assign o_temperature_target_value = state_q.temperature_target;
   assign o_pressure_window_reg      = state_q.pressure_window_reg;
   assign o_temperature_window_value = state_q.t_wnd;
   assign o_min_pressure             = state_q.p_min;

   // ****************************************************************
   // checks
   // ****************************************************************
   ttgt_write_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_wr_en && i_addr == ADDR_TEMPERATURE_TARGET)
      |=> (o_temperature_target_value == $past(i_wdata))
   ) else $error("temperature target not written");

   pwnd_order_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_wr_en && i_addr == ADDR_PRESSURE_WINDOW_HIGH)
      |=> (o_pressure_window_reg[15:8] == $past(i_wdata))
          && $stable(o_pressure_window_reg[7:0])
   ) else $error("pressure window high byte misplaced");

   twnd_write_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_wr_en && i_addr == ADDR_TEMPERATURE_WINDOW)
      |=> (o_temperature_window_value == $past(i_wdata))
   ) else $error("temperature window not written");

   min_holds_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (!i_wr_en && o_min_pressure != RST_PRES)
      |=> (o_min_pressure <= $past(o_min_pressure))
   ) else $error("captured minimum rose without a write");

   min_int_read_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_rd_en && i_addr == ADDR_MIN_PRESSURE_HIGH)
      |=> (o_rdata == $past(o_min_pressure[19:12]))
   ) else $error("minimum high byte readback wrong");

   min_frac_read_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_rd_en && i_addr == ADDR_MIN_PRESSURE_LOW)
      |=> (o_rdata[3:0] == LOW_RSVD_VAL)
          && (o_rdata[7:4] == $past(o_min_pressure[3:0]))
   ) else $error("minimum low byte readback wrong");

   min_clear_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_wr_en && i_addr == ADDR_MIN_PRESSURE_HIGH && i_wdata == RST_BYTE
       && !i_p_sample_valid)
      |=> (o_min_pressure[19:12] == RST_BYTE)
          && (o_min_pressure[11:0] == $past(o_min_pressure[11:0]))
   ) else $error("zero write did not clear minimum byte");

   ptgt_order_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_wr_en && i_addr == ADDR_PRESSURE_TARGET_LOW)
      |=> (o_pressure_target_value[7:0] == $past(i_wdata))
          && $stable(o_pressure_target_value[15:8])
   ) else $error("pressure target low byte misplaced");

   capture_zero_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (!i_wr_en && i_p_sample_valid && o_min_pressure == RST_PRES)
      |=> (o_min_pressure == $past(i_p_sample))
   ) else $error("cleared minimum did not take the sample");

   capture_less_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (!i_wr_en && i_p_sample_valid && i_p_sample < o_min_pressure)
      ##1 (!i_wr_en && !i_p_sample_valid)
      |=> (o_min_pressure == $past(i_p_sample, 2))
          && $stable(o_min_pressure)
   ) else $error("smaller sample not captured");

   idle_stable_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (!i_wr_en && !i_p_sample_valid) |=> $stable(o_min_pressure)
   ) else $error("minimum changed with no cause");

   rst_min_zero_a: assert property (
      @(posedge i_clk)
      !i_nrst
      |-> (o_min_pressure == RST_PRES) && (o_rdata == RST_BYTE)
   ) else $error("minimum not cleared in reset");

   rst_tgt_zero_a: assert property (
      @(posedge i_clk)
      !i_nrst
      |-> (o_pressure_target_value == RST_HALF) && (o_temperature_target_value == RST_BYTE)
   ) else $error("targets not cleared in reset");

   rst_wnd_zero_a: assert property (
      @(posedge i_clk)
      !i_nrst
      |-> (o_pressure_window_reg == RST_HALF) && (o_temperature_window_value == RST_BYTE)
   ) else $error("windows not cleared in reset");

   ptgt_high_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_wr_en && i_addr == ADDR_PRESSURE_TARGET_HIGH)
      |=> (o_pressure_target_value[15:8] == $past(i_wdata)) && $stable(o_pressure_target_value[7:0])
   ) else $error("pressure target high byte misplaced");

   pwnd_low_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_wr_en && i_addr == ADDR_PRESSURE_WINDOW_LOW)
      |=> (o_pressure_window_reg[7:0] == $past(i_wdata)) && $stable(o_pressure_window_reg[15:8])
   ) else $error("pressure window low byte misplaced");

   ptgt_read_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_rd_en && i_addr == ADDR_PRESSURE_TARGET_HIGH)
      |=> (o_rdata == $past(o_pressure_target_value[15:8]))
   ) else $error("pressure target high readback wrong");

   pwnd_read_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_rd_en && i_addr == ADDR_PRESSURE_WINDOW_LOW)
      |=> (o_rdata == $past(o_pressure_window_reg[7:0]))
   ) else $error("pressure window low readback wrong");

   ttgt_read_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_rd_en && i_addr == ADDR_TEMPERATURE_TARGET)
      |=> (o_rdata == $past(o_temperature_target_value))
   ) else $error("temperature target readback wrong");

   twnd_read_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_rd_en && i_addr == ADDR_TEMPERATURE_WINDOW)
      |=> (o_rdata == $past(o_temperature_window_value))
   ) else $error("temperature window readback wrong");

   min_mid_read_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_rd_en && i_addr == ADDR_MIN_PRESSURE_MID)
      |=> (o_rdata == $past(o_min_pressure[11:4]))
   ) else $error("minimum middle byte readback wrong");

   min_low_write_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_wr_en && i_addr == ADDR_MIN_PRESSURE_LOW && !i_p_sample_valid)
      |=> (o_min_pressure[3:0] == $past(i_wdata[7:4])) && $stable(o_min_pressure[19:4])
   ) else $error("minimum low byte write misplaced");

   min_mid_clear_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_wr_en && i_addr == ADDR_MIN_PRESSURE_MID && i_wdata == RST_BYTE && !i_p_sample_valid)
      |=> (o_min_pressure[11:4] == RST_BYTE)
   ) else $error("zero write did not clear middle byte");

   capture_keep_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (!i_wr_en && i_p_sample_valid && o_min_pressure != RST_PRES && i_p_sample >= o_min_pressure)
      |=> $stable(o_min_pressure)
   ) else $error("larger sample replaced the minimum");

   ttgt_hold_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !(i_wr_en && i_addr == ADDR_TEMPERATURE_TARGET)
      |=> $stable(o_temperature_target_value)
   ) else $error("temperature target changed without a write");

   twnd_hold_a: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !(i_wr_en && i_addr == ADDR_TEMPERATURE_WINDOW)
      |=> $stable(o_temperature_window_value)
   ) else $error("temperature window changed without a write");

endmodule : atmcr_regs
`default_nettype wire

// >>> testbench.sv
// testbench: self-checking run of the alarm threshold and minimum capture bank
// assumes the host model drives every access; reads are scored through a queue
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import atmcr_pkg::*;
   logic        clk;
   logic        nrst;
   logic        wr_en, rd_en, sv;
   logic [7:0]  addr, wdata, rdata, temperature_target, t_wnd;
   logic [15:0] pressure_target_value, pressure_window_reg;
   logic [19:0] smp, p_min;
   logic [7:0]  m [9];
   logic [7:0]  q [$];
   logic [31:0] lf;
   int          n_fail, n_checks, cyc;

   atmcr_host host (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
      .o_wdata(wdata), .o_p_sample_valid(sv), .o_p_sample(smp));
   atmcr_regs dut (.i_clk(clk), .i_nrst(nrst), .i_wr_en(wr_en), .i_rd_en(rd_en),
      .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_p_sample_valid(sv),
      .i_p_sample(smp), .o_pressure_target_value(pressure_target_value), .o_temperature_target_value(temperature_target),
      .o_pressure_window_reg(pressure_window_reg), .o_temperature_window_value(t_wnd),
      .o_min_pressure(p_min));

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nx

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // low byte of the minimum keeps only its top nibble
   // a read in the same cycle as the write returns the old value
   task automatic wr(input logic r, input logic [7:0] a, input logic [7:0] d);
      if (r) q.push_back((a >= 8'h16 && a <= 8'h1e) ? m[a - 8'h16] : 8'h00);
      host.acc(1'b1, r, a, d);
      if (a >= 8'h16 && a <= 8'h1e) m[a - 8'h16] = (a == 8'h1e) ? (d & 8'hf0) : d;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      q.push_back((a >= 8'h16 && a <= 8'h1e) ? m[a - 8'h16] : 8'h00);
      host.acc(1'b0, 1'b1, a, 8'h00);
   endtask : rd

   task automatic sample(input logic [19:0] s);
      logic [19:0] c;
      c = {m[6], m[7], m[8][7:4]};
      host.smp(s);
      if (c == 20'h00000 || s < c) {m[6], m[7], m[8]} = {s, 4'h0};
   endtask : sample

   // write lands first, then the sample is compared against it
   task automatic wr_smp(input logic [7:0] a, input logic [7:0] d, input logic [19:0] s);
      logic [19:0] c;
      fork
         host.acc(1'b1, 1'b0, a, d);
         host.smp(s);
      join
      m[a - 8'h16] = (a == 8'h1e) ? (d & 8'hf0) : d;
      c = {m[6], m[7], m[8][7:4]};
      if (c == 20'h00000 || s < c) {m[6], m[7], m[8]} = {s, 4'h0};
   endtask : wr_smp

   task automatic chk_regs();
      chk("pressure_target_value", {4'h0, m[0], m[1]}, {4'h0, pressure_target_value});
      chk("temperature_target", {12'h000, m[2]}, {12'h000, temperature_target});
      chk("pressure_window_reg", {4'h0, m[3], m[4]}, {4'h0, pressure_window_reg});
      chk("t_wnd", {12'h000, m[5]}, {12'h000, t_wnd});
      chk("p_min", {m[6], m[7], m[8][7:4]}, p_min);
   endtask : chk_regs

   // ****************************************************************
   // clock, watcher, timeout
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (rd_en === 1'b1 && nrst === 1'b1) begin
         @(negedge clk);
         chk("rdata", {12'h000, q.pop_front()}, {12'h000, rdata});
      end
   end

   // run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         stop_test();
      end
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      n_fail = 0;
      n_checks = 0;
      cyc = 0;
      lf = 32'h00015b18;
      foreach (m[i]) m[i] = 8'h00;
      nrst = 1'b0;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      for (int k = 0; k < 3; k++) begin
         chk_regs();
         for (int a = 8'h15; a <= 8'h1f; a++) rd(a[7:0]);
         for (int a = 8'h15; a <= 8'h1f; a++) begin
            lf = nx(lf);
            wr(lf[8], a[7:0], lf[7:0]);
         end
      end
      for (int k = 0; k < 12; k++) begin
         if (k % 4 == 0) begin
            host.clr();
            {m[6], m[7], m[8]} = 24'h000000;
            chk_regs();
         end
         lf = nx(lf);
         sample(lf[19:0] >> k[1:0]);
         chk_regs();
         for (int a = 8'h1c; a <= 8'h1e; a++) rd(a[7:0]);
         if (k % 4 == 3) begin
            wr_smp(8'h1c + 8'(k / 4), 8'h00, lf[31:12]);
            chk_regs();
         end
      end
      @(negedge clk);
      nrst = 1'b0;
      foreach (m[i]) m[i] = 8'h00;
      @(negedge clk);
      chk_regs();
      nrst = 1'b1;
      rd(8'h1c);
      sample(20'h00abc);
      chk_regs();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
